// ==== rtl/baud_gen.sv ====
// bit-rate generator for the serial port, with a classic Wishbone register slave
module baud_gen
    import baud_gen_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [4:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic        RECEIVE_IDLE,
    output logic             WB_ACK_O,
    output logic [31:0]      WB_DAT_O,
    output logic             BIT_TICK,
    output logic             SYNC_MODE,
    output logic             HIGH_SPEED
);

    typedef struct packed {
        wb_rsp_s          rsp;
        logic [7:0]       baud_control;
        logic [7:0]       receive_status_control;
        logic [7:0]       divisor_low_byte;
        logic [7:0]       divisor_high_byte;
        logic [7:0]       transmit_status_control;
        logic [PRE_W-1:0] prescale;
        logic [15:0]      bit_rate_timer;
        logic             tick;
        logic [2:0]       idle_sync;
        logic             idle;
    } state_s;

    state_s  r;
    state_s  next_r;
    wb_req_s req;
    wb_rsp_s idle_rsp;

    assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
                   adr: WB_ADR_I[ADDR_W+1:2], sel: WB_SEL_I, dat: WB_DAT_I};
    assign idle_rsp = '{ack: 1'b0, dat: 32'h0000_0000};

    logic             wide;
    logic             hs;
    logic             sync;
    logic [15:0]      divisor;
    logic [PRE_W-1:0] pre_last;
    logic             access;
    logic             wr_lane0;
    logic             divisor_write;
    logic [7:0]       rd_byte;

    always_comb begin
        wide = r.baud_control[BC_WIDE_DIVISOR];
        hs   = r.transmit_status_control[TS_HIGH_SPEED];
        sync = r.transmit_status_control[TS_SYNC_MODE];
        // high byte only counts in wide mode
        divisor = wide ? {r.divisor_high_byte, r.divisor_low_byte}
                       : {8'h00, r.divisor_low_byte};
        // prescale before each timer step; sync ignores high-speed
        if (sync)
            pre_last = PRE_W'(PRE_X4 - 1);
        else if (!wide && !hs)
            pre_last = PRE_W'(PRE_X64 - 1);
        else if (wide && hs)
            pre_last = PRE_W'(PRE_X4 - 1);
        else
            pre_last = PRE_W'(PRE_X16 - 1);
    end

    always_comb begin
        access        = req.cyc && req.stb && !r.rsp.ack;
        wr_lane0      = access && req.we && req.sel[0];
        divisor_write = wr_lane0 && (req.adr == IDX_DIVISOR_LOW || req.adr == IDX_DIVISOR_HIGH);
        case (req.adr)
            IDX_BAUD_CONTROL:    rd_byte = r.baud_control;
            IDX_RECEIVE_STATUS:  rd_byte = r.receive_status_control;
            IDX_DIVISOR_LOW:     rd_byte = r.divisor_low_byte;
            IDX_DIVISOR_HIGH:    rd_byte = r.divisor_high_byte;
            IDX_TRANSMIT_STATUS: rd_byte = r.transmit_status_control;
            default:             rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;

        // receive-idle pin: three stages, change counts when stages 2 and 3 agree
        next_r.idle_sync = {r.idle_sync[1:0], RECEIVE_IDLE};
        if (r.idle_sync[2] == r.idle_sync[1])
            next_r.idle = r.idle_sync[2];
        next_r.baud_control[BC_RECEIVE_IDLE] = r.idle;

        // bus slave: one-cycle ack, unmapped reads return zero, writes ignored
        next_r.rsp = idle_rsp;
        if (access) begin
            next_r.rsp.ack = 1'b1;
            next_r.rsp.dat = {24'h00_0000, rd_byte};
        end
        if (wr_lane0) begin
            case (req.adr)
                IDX_BAUD_CONTROL:
                    next_r.baud_control = (r.baud_control & ~BC_WMASK)
                                        | (req.dat[7:0] & BC_WMASK);
                IDX_RECEIVE_STATUS:
                    next_r.receive_status_control = req.dat[7:0] & RS_WMASK;
                IDX_DIVISOR_LOW:
                    next_r.divisor_low_byte = req.dat[7:0];
                IDX_DIVISOR_HIGH:
                    next_r.divisor_high_byte = req.dat[7:0];
                IDX_TRANSMIT_STATUS:
                    next_r.transmit_status_control = req.dat[7:0] & TS_WMASK;
                default: ;
            endcase
        end

        // free-running down-timer, one tick per (divisor+1) prescaled steps
        if (divisor_write) begin
            // restart from zero so the new rate shows on the next period
            next_r.prescale       = '0;
            next_r.bit_rate_timer = '0;
        end else if (r.prescale >= pre_last) begin
            next_r.prescale = '0;
            if (r.bit_rate_timer == 16'h0000) begin
                next_r.bit_rate_timer = divisor;
                next_r.tick           = 1'b1;
            end else begin
                next_r.bit_rate_timer = r.bit_rate_timer - 16'h0001;
            end
        end else begin
            next_r.prescale = r.prescale + PRE_W'(1);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign WB_ACK_O   = r.rsp.ack;
    assign WB_DAT_O   = r.rsp.dat;
    assign BIT_TICK   = r.tick;
    assign SYNC_MODE  = r.transmit_status_control[TS_SYNC_MODE];
    assign HIGH_SPEED = r.transmit_status_control[TS_HIGH_SPEED];

endmodule // baud_gen

// ==== rtl/baud_gen_pkg.sv ====
// package: register map, field positions and mode constants for the bit-rate generator
package baud_gen_pkg;

    localparam int ADDR_W = 3;

    // word offsets (byte address = index * 4)
    localparam logic [ADDR_W-1:0] IDX_BAUD_CONTROL    = 3'h0;
    localparam logic [ADDR_W-1:0] IDX_RECEIVE_STATUS  = 3'h1;
    localparam logic [ADDR_W-1:0] IDX_DIVISOR_LOW     = 3'h2;
    localparam logic [ADDR_W-1:0] IDX_DIVISOR_HIGH    = 3'h3;
    localparam logic [ADDR_W-1:0] IDX_TRANSMIT_STATUS = 3'h4;

    // baud_control fields
    localparam int BC_RECEIVE_IDLE   = 6;
    localparam int BC_WIDE_DIVISOR   = 3;
    // transmit_status_control fields
    localparam int TS_SYNC_MODE      = 4;
    localparam int TS_HIGH_SPEED     = 2;

    // writable masks; other bits are held elsewhere or read as zero
    localparam logic [7:0] BC_WMASK  = 8'h08;
    localparam logic [7:0] RS_WMASK  = 8'hFF;
    localparam logic [7:0] TS_WMASK  = 8'hFF;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // prescale lengths in system clocks per timer step
    localparam int PRE_X64 = 64;
    localparam int PRE_X16 = 16;
    localparam int PRE_X4  = 4;
    localparam int PRE_W   = 6;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADDR_W-1:0] adr;
        logic [3:0]        sel;
        logic [31:0]       dat;
    } wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;

endpackage

// ==== tb/baud_gen_checker.sv ====
// checker: handshake, tick spacing and mode copies of the bit-rate generator
module baud_gen_checker import baud_gen_pkg::*; (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [4:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic        RECEIVE_IDLE,
    input wire logic        WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        BIT_TICK,
    input wire logic        SYNC_MODE,
    input wire logic        HIGH_SPEED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire logic take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire logic tw   = take && WB_WE_I && WB_SEL_I[0];
    property p_ack; take |=> WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_once; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_once: assert property (p_once) else $error("ack too long");
    property p_hi; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000; endproperty
    a_hi: assert property (p_hi) else $error("read upper bits set");
    property p_unm; take && !WB_WE_I && WB_ADR_I[4:2] > 3'h4 |=> WB_DAT_O == 32'h0000_0000;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_sync; tw && WB_ADR_I[4:2] == 3'h4 |-> ##2 SYNC_MODE == $past(WB_DAT_I[4], 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync copy wrong");
    property p_hs; tw && WB_ADR_I[4:2] == 3'h4 |-> ##2 HIGH_SPEED == $past(WB_DAT_I[2], 2);
    endproperty
    a_hs: assert property (p_hs) else $error("high speed copy wrong");
    // a divisor write restarts the count, so no stale tick right after it
    property p_clr; tw && WB_ADR_I[4:3] == 2'b01 |-> ##2 !BIT_TICK [*2]; endproperty
    a_clr: assert property (p_clr) else $error("tick after divisor write");
    property p_gap; BIT_TICK |=> !BIT_TICK [*3]; endproperty
    a_gap: assert property (p_gap) else $error("ticks too close");
    property p_rst; $fell(RST) |-> !BIT_TICK [*3]; endproperty
    a_rst: assert property (p_rst) else $error("tick right after reset");
    c_tick: cover property (BIT_TICK);
    c_sync: cover property (SYNC_MODE && BIT_TICK);
    c_div: cover property (tw && WB_ADR_I[4:2] == 3'h3);
endmodule // baud_gen_checker

// ==== tb/baud_gen_tb_top.sv ====
// testbench: register access and tick period checks of the bit-rate generator
module baud_gen_tb_top import baud_gen_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        rx_idle = 1'b0;
    wb_req_s     req = '0;
    wb_rsp_s     rsp;
    logic        tick;
    logic [31:0] rd_val;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          n;
    int          p;
    // ts, bc, high, low, prescale, period; high byte must be ignored in 8-bit rows
    int cfg [7][6] = '{'{0, 0, 1, 2, 64, 192}, '{4, 0, 1, 2, 16, 48}, '{0, 8, 1, 2, 16, 4144},
        '{4, 8, 1, 2, 4, 1036}, '{16, 0, 1, 2, 4, 12}, '{20, 0, 1, 2, 4, 12},
        '{20, 8, 1, 2, 4, 1036}};
    baud_gen dut_u (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(req.cyc), .WB_STB_I(req.stb),
        .WB_WE_I(req.we), .WB_ADR_I({req.adr, 2'b00}), .WB_SEL_I(req.sel),
        .WB_DAT_I(req.dat), .RECEIVE_IDLE(rx_idle), .WB_ACK_O(rsp.ack), .WB_DAT_O(rsp.dat),
        .BIT_TICK(tick), .SYNC_MODE(), .HIGH_SPEED());
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic we, input logic [ADDR_W-1:0] idx, input logic [7:0] d);
        int k = 0;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b1, we, idx, 4'h1, {24'h00_0000, d}};
        do begin
            @(posedge ref_clk);
            k++;
        end while (rsp.ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            bad_count++;
            conclude();
        end
        rd_val = rsp.dat;
        req <= '0;
    endtask
    // counts edges until the next tick; bounded so a dead timer cannot hang
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            #1;
            c++;
        end while (tick !== 1'b1 && c < 9000);
        if (c >= 9000) begin
            bad_count++;
            conclude();
        end
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rx_idle <= 1'b1;
        bus(1'b0, IDX_TRANSMIT_STATUS, 8'h00);
        chk(rd_val, 32'h0000_0000);
        bus(1'b1, IDX_BAUD_CONTROL, 8'hFF);
        bus(1'b0, IDX_BAUD_CONTROL, 8'h00);
        chk(rd_val, 32'h0000_0048);
        bus(1'b0, 3'h7, 8'h00);
        chk(rd_val, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, IDX_TRANSMIT_STATUS, 8'(cfg[i][0]));
            bus(1'b1, IDX_BAUD_CONTROL, 8'(cfg[i][1]));
            bus(1'b1, IDX_DIVISOR_HIGH, 8'(cfg[i][2]));
            bus(1'b1, IDX_DIVISOR_LOW, 8'(cfg[i][3]));
            wait_tick(n);
            // write edge, ack edge, then P-1 sampled edges until the first tick
            chk(32'(n), 32'(cfg[i][4] - 1));
            wait_tick(p);
            chk(32'(p), 32'(cfg[i][5]));
        end
        bus(1'b0, IDX_DIVISOR_HIGH, 8'h00);
        chk(rd_val, 32'h0000_0001);
        conclude();
    end
endmodule // baud_gen_tb_top
bind baud_gen baud_gen_checker chk_u (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .RECEIVE_IDLE(RECEIVE_IDLE), .WB_ACK_O(WB_ACK_O),
    .WB_DAT_O(WB_DAT_O), .BIT_TICK(BIT_TICK), .SYNC_MODE(SYNC_MODE), .HIGH_SPEED(HIGH_SPEED));
